// ### rtl/dmem_addr_pkg.sv
/*
  Constants, types and field layout for the data memory address generator and ALU flag block.
  Assumes a single 50 MHz core clock and a Wishbone classic register port.
*/
package dmem_addr_pkg;
  localparam int ADDR_W = 12;
  localparam int NUM_PTR = 3;
  // Register word offsets on the Wishbone port
  localparam logic [3:0] OFS_BANK = 4'h0;
  localparam logic [3:0] OFS_FLAGS = 4'h1;
  localparam logic [3:0] OFS_RCAUSE = 4'h2;
  localparam logic [3:0] OFS_PTR0L = 4'h3;
  localparam logic [3:0] OFS_IMPL = 4'h9;
  // Field layout
  localparam int FLG_N = 4;
  localparam int FLG_OV = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_MASK = 8'h1f;
  localparam logic [7:0] BANK_MASK = 8'h0f;
  localparam logic [7:0] RCAUSE_MASK = 8'hdf;
  localparam int RC_BOR = 0;
  // Reset values
  localparam logic [7:0] RCAUSE_RST = 8'h1c;
  localparam logic [15:0] IMPL_RST = 16'hffff;
  // Access bank split point
  localparam logic [7:0] ACC_SPLIT = 8'h60;
  localparam logic [3:0] BANK_SFR = 4'hf;
  // Flag register location in bank 15
  localparam logic [7:0] FLAGS_SFR = 8'hd8;
  // Indirect port layout in bank 15, offsets of each port group
  localparam logic [7:0] PORT_BASE0 = 8'heb;
  localparam logic [7:0] PORT_BASE1 = 8'he3;
  localparam logic [7:0] PORT_BASE2 = 8'hdb;
  // Pointer register addresses in bank 15
  localparam logic [7:0] PTRL_BASE0 = 8'he9;
  localparam logic [7:0] PTRL_BASE1 = 8'he1;
  localparam logic [7:0] PTRL_BASE2 = 8'hd9;

  typedef enum logic [2:0] {
    PM_NONE = 3'h0, PM_PTR_POST_DECREMENT_PORT = 3'h1, PM_PTR_POST_INCREMENT_PORT = 3'h2, PM_PTR_PRE_INCREMENT_PORT = 3'h3, PM_OFFSET = 3'h4
  } ptr_mode_t;

  typedef enum logic [1:0] {
    AK_NONE = 2'h0, AK_ADDSUB = 2'h1, AK_ROT = 2'h2, AK_LOGIC = 2'h3
  } alu_kind_t;

  // Memory request from the decoder
  typedef struct packed {
    logic valid;
    logic write;
    logic full_addr;
    logic access_bit;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  // ALU result from the datapath
  typedef struct packed {
    logic valid;
    alu_kind_t kind;
    logic sub;
    logic rot_left;
    logic [7:0] src;
    logic [7:0] opb;
    logic [7:0] result;
    logic [4:0] affect;
  } alu_res_t;

  // Physical access toward storage
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } mem_acc_t;
endpackage

// ### rtl/dmem_addr.sv
/*
  Data memory address generator with bank select, three indirect pointers and the ALU flag register.
  Assumes storage answers reads combinationally on MEM_RDATA and the decoder issues one request per cycle.
*/
`timescale 1ns/1ps
module dmem_addr
  import dmem_addr_pkg::*;
#(
  parameter int BANKS = 16
) (
  // Clock and reset
  input wire logic REF_CLK,
  input wire logic RST_N,
  // Configuration strap and working register offset
  input wire logic BROWNOUT_ENABLE_CFG_CFG,
  input wire logic [7:0] W_REG,
  // Decoder request and load bank literal
  input wire mem_req_t REQ,
  input wire logic BANK_LOAD,
  input wire logic [3:0] BANK_LIT,
  // ALU result
  input wire alu_res_t ALU,
  // Storage side
  output mem_acc_t MEM,
  input wire logic [7:0] MEM_RDATA,
  output logic [7:0] RDATA,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [5:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  output logic WB_ERR_O
);
  logic [3:0] bank_q, bank_d;
  logic [4:0] flags_q, flags_d;
  logic [7:0] rcause_q, rcause_d;
  logic [BANKS-1:0] impl_q, impl_d;
  logic [11:0] ptr_q [NUM_PTR], ptr_d [NUM_PTR];
  logic ack_q, ack_d, err_q, err_d;
  logic [31:0] dat_q, dat_d;
  logic por_q, por_d;
  logic [11:0] ea;
  logic bank_ok, ind_hit, ind_self;
  logic [7:0] rd_val;
  logic [1:0] sel_ptr;
  ptr_mode_t sel_mode;

  function automatic logic [2:0] port_of(input logic [7:0] ofs, input logic [7:0] base);
    logic [7:0] d;
    d = ofs - base;
    port_of = (d < 8'h5) ? d[2:0] : 3'h7;
  endfunction

  // Address formation and indirect port decode
  always_comb begin
    logic [11:0] a0;
    logic [2:0] p;
    a0 = '0;
    p = 3'h7;
    sel_ptr = '0;
    sel_mode = PM_NONE;
    ind_hit = 1'b0;
    if (REQ.full_addr) begin
      a0 = REQ.addr;
    end else if (!REQ.access_bit) begin
      a0 = {(REQ.addr[7:0] < ACC_SPLIT) ? 4'h0 : BANK_SFR, REQ.addr[7:0]};
    end else begin
      a0 = {bank_q, REQ.addr[7:0]};
    end
    ea = a0;
    if (a0[11:8] == BANK_SFR) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        p = port_of(a0[7:0], (i == 0) ? PORT_BASE0 : (i == 1) ? PORT_BASE1 : PORT_BASE2);
        if (p != 3'h7) begin
          ind_hit = 1'b1;
          sel_ptr = 2'(i);
          // Port order from base: offset, ptr_pre_increment_port, ptr_post_decrement_port, ptr_post_increment_port, plain
          unique case (p)
            3'h0: sel_mode = PM_OFFSET;
            3'h1: sel_mode = PM_PTR_PRE_INCREMENT_PORT;
            3'h2: sel_mode = PM_PTR_POST_DECREMENT_PORT;
            3'h3: sel_mode = PM_PTR_POST_INCREMENT_PORT;
            default: sel_mode = PM_NONE;
          endcase
        end
      end
    end
    if (ind_hit) begin
      unique case (sel_mode)
        PM_OFFSET: ea = ptr_q[sel_ptr] + {{4{W_REG[7]}}, W_REG};
        PM_PTR_PRE_INCREMENT_PORT: ea = ptr_q[sel_ptr] + 12'h001;
        default: ea = ptr_q[sel_ptr];
      endcase
    end
  end

  // A pointer aimed at any data port gives zero and ignores writes
  always_comb begin
    ind_self = 1'b0;
    for (int i = 0; i < NUM_PTR; i++) begin
      if (ea[11:8] == BANK_SFR &&
          port_of(ea[7:0], (i == 0) ? PORT_BASE0 : (i == 1) ? PORT_BASE1 : PORT_BASE2) != 3'h7) begin
        ind_self = ind_hit;
      end
    end
  end

  assign bank_ok = impl_q[ea[11:8]];

  // Self-pointing and unimplemented-bank reads give zero instead of storage data
  always_comb begin
    rd_val = MEM_RDATA;
    if (ind_self || !bank_ok) begin
      rd_val = 8'h00;
    end
    RDATA = rd_val;
    MEM.rd = REQ.valid && !REQ.write && bank_ok && !ind_self;
    MEM.wr = REQ.valid && REQ.write && bank_ok && !ind_self;
    MEM.addr = ea;
    MEM.wdata = REQ.wdata;
  end

  // Pointers, flags and bank select next state
  always_comb begin
    logic [8:0] sum;
    logic [4:0] nib;
    logic [4:0] alu_f;
    logic [4:0] sw_wr;
    bank_d = bank_q;
    flags_d = flags_q;
    for (int i = 0; i < NUM_PTR; i++) begin
      ptr_d[i] = ptr_q[i];
    end
    sum = '0;
    nib = '0;
    alu_f = flags_q;
    sw_wr = 5'h00;
    if (BANK_LOAD) begin
      bank_d = BANK_LIT;
    end
    if (REQ.valid && ind_hit && !ind_self) begin
      unique case (sel_mode)
        PM_PTR_POST_DECREMENT_PORT: ptr_d[sel_ptr] = ptr_q[sel_ptr] - 12'h001;
        PM_PTR_POST_INCREMENT_PORT, PM_PTR_PRE_INCREMENT_PORT: ptr_d[sel_ptr] = ptr_q[sel_ptr] + 12'h001;
        default: ptr_d[sel_ptr] = ptr_q[sel_ptr];
      endcase
    end
    if (MEM.wr && ea[11:8] == BANK_SFR) begin
      for (int i = 0; i < NUM_PTR; i++) begin
        logic [7:0] lo;
        lo = (i == 0) ? PTRL_BASE0 : (i == 1) ? PTRL_BASE1 : PTRL_BASE2;
        if (ea[7:0] == lo) begin
          ptr_d[i][7:0] = REQ.wdata;
        end
        if (ea[7:0] == lo + 8'h01) begin
          ptr_d[i][11:8] = REQ.wdata[3:0];
        end
      end
    end
    // Arithmetic flag computation
    if (ALU.valid) begin
      unique case (ALU.kind)
        AK_ADDSUB: begin
          sum = {1'b0, ALU.src} + {1'b0, ALU.sub ? ~ALU.opb : ALU.opb} + {8'h00, ALU.sub};
          nib = {1'b0, ALU.src[3:0]} + {1'b0, ALU.sub ? ~ALU.opb[3:0] : ALU.opb[3:0]} + {4'h0, ALU.sub};
          alu_f[FLG_C] = sum[8];
          alu_f[FLG_DC] = nib[4];
          alu_f[FLG_OV] = (ALU.src[7] == (ALU.opb[7] ^ ALU.sub)) && (ALU.result[7] != ALU.src[7]);
        end
        AK_ROT: begin
          alu_f[FLG_C] = ALU.rot_left ? ALU.src[7] : ALU.src[0];
          alu_f[FLG_DC] = ALU.rot_left ? ALU.src[3] : ALU.src[4];
        end
        default: alu_f = flags_q;
      endcase
      alu_f[FLG_N] = ALU.result[7];
      alu_f[FLG_Z] = (ALU.result == 8'h00);
    end
    if (REQ.valid && ind_self && !REQ.write) begin
      alu_f[FLG_Z] = 1'b1;
    end
    // Direct writes land only where the ALU does not claim the bit
    if (MEM.wr && ea == {BANK_SFR, FLAGS_SFR}) begin
      sw_wr = ALU.valid ? ~ALU.affect : 5'h1f;
    end
    for (int b = 0; b < 5; b++) begin
      if (sw_wr[b]) begin
        flags_d[b] = REQ.wdata[b];
      end else if (ALU.valid && ALU.affect[b]) begin
        flags_d[b] = alu_f[b];
      end else if (REQ.valid && ind_self && !REQ.write && b == FLG_Z) begin
        flags_d[b] = 1'b1;
      end
    end
  end

  // Wishbone register port
  always_comb begin
    logic hit;
    hit = WB_CYC_I && WB_STB_I && !ack_q && !err_q;
    ack_d = 1'b0;
    err_d = 1'b0;
    dat_d = dat_q;
    rcause_d = rcause_q;
    impl_d = impl_q;
    por_d = 1'b0;
    if (por_q) begin
      rcause_d[RC_BOR] = BROWNOUT_ENABLE_CFG_CFG;
    end
    if (hit) begin
      ack_d = 1'b1;
      dat_d = 32'h0;
      unique case (WB_ADR_I[5:2])
        OFS_BANK: dat_d[7:0] = {4'h0, bank_q};
        OFS_FLAGS: dat_d[7:0] = {3'h0, flags_q};
        OFS_RCAUSE: begin
          dat_d[7:0] = rcause_q & RCAUSE_MASK;
          if (WB_WE_I && WB_SEL_I[0]) begin
            rcause_d = WB_DAT_I[7:0] & RCAUSE_MASK;
          end
        end
        OFS_IMPL: begin
          dat_d[15:0] = 16'(impl_q);
          if (WB_WE_I && WB_SEL_I[0]) begin
            impl_d[7:0] = WB_DAT_I[7:0];
          end
          if (WB_WE_I && WB_SEL_I[1]) begin
            impl_d[BANKS-1:8] = WB_DAT_I[BANKS-1:8];
          end
        end
        default: begin
          ack_d = 1'b0;
          err_d = 1'b1;
        end
      endcase
    end
  end

  // Software bank and flag writes over Wishbone share the core next-state
  logic [3:0] bank_n;
  logic [4:0] flags_n;
  always_comb begin
    bank_n = bank_d;
    flags_n = flags_d;
    if (WB_CYC_I && WB_STB_I && !ack_q && WB_WE_I && WB_SEL_I[0]) begin
      if (WB_ADR_I[5:2] == OFS_BANK) begin
        bank_n = WB_DAT_I[3:0] & BANK_MASK[3:0];
      end
      if (WB_ADR_I[5:2] == OFS_FLAGS) begin
        flags_n = WB_DAT_I[4:0] & FLAGS_MASK[4:0];
      end
    end
  end

  // Flags have no defined reset value in hardware; zero is used here
  always_ff @(posedge REF_CLK) begin
    if (!RST_N) begin
      bank_q <= '0;
      flags_q <= '0;
      rcause_q <= RCAUSE_RST;
      impl_q <= BANKS'(IMPL_RST);
      ack_q <= 1'b0;
      err_q <= 1'b0;
      dat_q <= '0;
      por_q <= 1'b1;
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_q[i] <= '0;
      end
    end else begin
      bank_q <= bank_n;
      flags_q <= flags_n;
      rcause_q <= rcause_d;
      impl_q <= impl_d;
      ack_q <= ack_d;
      err_q <= err_d;
      dat_q <= dat_d;
      por_q <= por_d;
      for (int i = 0; i < NUM_PTR; i++) begin
        ptr_q[i] <= ptr_d[i];
      end
    end
  end

  assign WB_ACK_O = ack_q;
  assign WB_ERR_O = err_q;
  assign WB_DAT_O = dat_q;

  AST_ZERO_FLAG: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ALU.valid && ALU.affect[FLG_Z] && !MEM.wr && !ind_self |=> flags_q[FLG_Z] == ($past(ALU.result) == 8'h00))
    else $error("zero flag mismatch");
  AST_NEG_FLAG: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    ALU.valid && ALU.affect[FLG_N] && !MEM.wr |=> flags_q[FLG_N] == $past(ALU.result[7]))
    else $error("negative flag mismatch");
  AST_DIRECT_ADDR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REQ.valid && !REQ.full_addr && REQ.access_bit && !ind_hit |-> MEM.addr[11:8] == bank_q)
    else $error("direct address bank wrong");
  AST_FULL_ADDR: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REQ.valid && REQ.full_addr && !ind_hit |-> MEM.addr == REQ.addr)
    else $error("full address altered");
  AST_UNIMPL_DROP: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    !bank_ok |-> !MEM.wr && RDATA == 8'h00)
    else $error("unimplemented bank accessed");
  AST_SELF_READ: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    REQ.valid && ind_self |-> RDATA == 8'h00 && !MEM.wr)
    else $error("self indirect not blocked");
  AST_WB_ACK: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  AST_BANK_HIGH: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    WB_ACK_O && $past(WB_ADR_I[5:2]) == OFS_BANK |-> WB_DAT_O[7:4] == 4'h0)
    else $error("bank upper bits nonzero");
endmodule

// ### sim/dmem_store_model.sv
/*
  Behavioural data storage on the memory side of the address generator.
  Assumes rd, wr, address and write data are presented combinationally for one cycle.
*/
`timescale 1ns/1ps
module dmem_store_model
  import dmem_addr_pkg::*;
(
  // Clock
  input wire logic clk,
  // Access from the block
  input wire mem_acc_t acc,
  output logic [7:0] rdata
);
  logic [7:0] ram [0:4095];
  initial begin
    for (int i = 0; i < 4096; i++) begin
      ram[i] = i[7:0] ^ 8'h5a;
    end
  end
  // Flat static storage, 256 locations in each bank
  always @(posedge clk) begin
    if (acc.wr) begin
      ram[acc.addr] <= acc.wdata;
    end
  end
  // Without a read strobe, show a changing pattern so stale data cannot pass
  assign rdata = acc.rd ? ram[acc.addr] : ~acc.addr[7:0];
endmodule

// ### sim/dmem_addr_tb_top.sv
/*
  Self-checking bench for the data memory address generator and flag block.
  Assumes the storage model on the memory side and a 50 MHz clock.
*/
`timescale 1ns/1ps
module dmem_addr_tb_top
  import dmem_addr_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic brownout_enable_cfg = 1'b1;
  logic [7:0] w_reg = 8'h00;
  mem_req_t req = '0;
  logic bload = 1'b0;
  logic [3:0] blit = 4'h0;
  alu_res_t alu = '0;
  mem_acc_t mem;
  logic [7:0] mrd;
  logic [7:0] rdata;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [5:0] adr = 6'h00;
  logic [31:0] dati = 32'h0;
  logic [31:0] dato;
  logic ack;
  logic err;
  logic [31:0] rq;
  logic re;
  int errors = 0;
  int checked = 0;
  // Rows: bank, full, access bit, address, expected address
  logic [35:0] rows [5] = '{36'h301045345, 36'hf010fffff, 36'h3107ab7ab, 36'h30005f05f, 36'h300060f60};
  // Steps: write, address, data, expected address
  logic [35:0] st [18] = '{36'h1fe9ff000, 36'h1fea01000, 36'h0fee001ff, 36'h0fef00200, 36'h0fed00200,
    36'h0fec00200, 36'h0feb001fe, 36'h0fef00200, 36'h1fe134000, 36'h1fe20a000, 36'h0fe700a34,
    36'h1fd956000, 36'h1fda0b000, 36'h0fdf00b56, 36'h1fe9e9000, 36'h1fea0f000, 36'h1fee40000, 36'h0fef00f40};
  // ALU cases: kind, sub, rotate left, source, operand, result, expected flags
  logic [39:0] av [5] = '{40'h047f01801a, 40'h04ff010007, 40'h048888100b, 40'h0605050007, 40'h0988001103};

  always #10 clk = ~clk;

  dmem_addr i_dmem_addr (
    .REF_CLK(clk), .RST_N(rst_n), .BROWNOUT_ENABLE_CFG_CFG(brownout_enable_cfg), .W_REG(w_reg), .REQ(req), .BANK_LOAD(bload),
    .BANK_LIT(blit), .ALU(alu), .MEM(mem), .MEM_RDATA(mrd), .RDATA(rdata), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'h1), .WB_DAT_I(dati), .WB_DAT_O(dato),
    .WB_ACK_O(ack), .WB_ERR_O(err)
  );
  dmem_store_model i_dmem_store_model (.clk(clk), .acc(mem), .rdata(mrd));

  task automatic wrap_up();
    $display("checked=%0d errors=%0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk_a(input logic [11:0] ex, input logic [11:0] got);
    checked++;
    if (got !== ex) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  task automatic chk_d(input logic [31:0] ex, input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, ex, got);
    end
  endtask

  // Classic single cycle; also retires any core request or ALU pulse
  task automatic wb(input logic w, input logic [3:0] idx, input logic [31:0] d);
    int n;
    @(posedge clk);
    req <= '0;
    alu <= '0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dati <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    rq = dato;
    re = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (n >= 50) begin
      errors++;
      wrap_up();
    end
  endtask

  task automatic core(input logic f, input logic a, input logic w, input logic [11:0] ad, input logic [7:0] wd);
    @(posedge clk);
    req <= '{1'b1, w, f, a, ad, wd};
    #1;
  endtask

  task automatic bank(input logic [3:0] b);
    @(posedge clk);
    req <= '0;
    bload <= 1'b1;
    blit <= b;
    @(posedge clk);
    bload <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    wb(1'b0, OFS_RCAUSE, 32'h0);
    chk_d({24'h0, RCAUSE_RST | 8'h01}, rq);
    wb(1'b1, OFS_RCAUSE, 32'h1f);
    wb(1'b0, OFS_RCAUSE, 32'h0);
    chk_d(32'h1f, rq);
    wb(1'b1, OFS_BANK, 32'hff);
    wb(1'b0, OFS_BANK, 32'h0);
    chk_d(32'h0f, rq);
    wb(1'b1, OFS_FLAGS, 32'hff);
    wb(1'b0, OFS_FLAGS, 32'h0);
    chk_d(32'h1f, rq);
    wb(1'b0, 4'h5, 32'h0);
    chk_d(32'h1, {31'h0, re});
    $display("registers done");
    foreach (rows[i]) begin
      bank(rows[i][35:32]);
      core(rows[i][28], rows[i][24], 1'b0, rows[i][23:12], 8'h00);
      chk_a(rows[i][11:0], mem.addr);
    end
    $display("direct addressing done");
    w_reg <= 8'hfe;
    foreach (st[i]) begin
      core(1'b1, 1'b0, st[i][32], st[i][31:20], st[i][19:12]);
      if (!st[i][32]) chk_a(st[i][11:0], mem.addr);
      if (!st[i][32]) chk_d(32'h1, {31'h0, mem.rd});
    end
    $display("indirect addressing done");
    // Pointer wraps to zero without touching the zero flag, then a self-pointing read sets it
    wb(1'b1, OFS_FLAGS, 32'h0);
    core(1'b1, 1'b0, 1'b1, 12'hfe9, 8'hff);
    core(1'b1, 1'b0, 1'b1, 12'hfea, 8'h0f);
    core(1'b1, 1'b0, 1'b0, 12'hfee, 8'h00);
    wb(1'b0, OFS_FLAGS, 32'h0);
    chk_d(32'h0, rq);
    core(1'b1, 1'b0, 1'b1, 12'hfe9, 8'hef);
    core(1'b1, 1'b0, 1'b1, 12'hfea, 8'h0f);
    core(1'b1, 1'b0, 1'b0, 12'hfef, 8'h00);
    chk_d(32'h0, rdata);
    wb(1'b0, OFS_FLAGS, 32'h0);
    chk_d(32'h4, rq & 32'h4);
    $display("pointer corner cases done");
    // Each ALU case also writes the flag register, which must lose
    foreach (av[i]) begin
      @(posedge clk);
      alu <= '{1'b1, alu_kind_t'(av[i][35:34]), av[i][33], av[i][32], av[i][31:24], av[i][23:16], av[i][15:8], 5'h1f};
      req <= '{1'b1, 1'b1, 1'b1, 1'b0, 12'hfd8, 8'h1f ^ av[i][7:0]};
      wb(1'b0, OFS_FLAGS, 32'h0);
      chk_d({24'h0, av[i][7:0]}, rq);
    end
    $display("flags done");
    wb(1'b1, OFS_IMPL, 32'hfff7);
    bank(4'h3);
    core(1'b0, 1'b1, 1'b1, 12'h012, 8'h5a);
    chk_d(32'h0, {31'h0, mem.wr});
    core(1'b0, 1'b1, 1'b0, 12'h012, 8'h00);
    chk_d(32'h0, rdata);
    $display("unimplemented bank done");
    wrap_up();
  end
endmodule
